// ---- i2c_expander_pkg.sv ----
// Purpose: Shared constants and state types for the two-wire port expander link.
// Assumes: 16 port bits split into a low and a high byte.
// Notes: The slave address default is arbitrary.
package i2c_expander_pkg;
   localparam int BYTE_W = 8;
   localparam int PORT_W = 16;
   localparam logic [3:0] BYTE_CNT = 4'h8;
   localparam logic [15:0] PORT_RESET = 16'hFFFF;
   localparam logic RW_READ = 1'b1;
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
   localparam int QUARTER_DEFAULT = 50;
   localparam logic [1:0] LAST_BYTE = 2'h2;

   typedef enum logic [2:0] {
      D_IDLE = 3'h0,
      D_ADDR = 3'h1,
      D_ACKA = 3'h3,
      D_WR = 3'h2,
      D_ACKW = 3'h6,
      D_RD = 3'h7,
      D_MACK = 3'h5
   } dev_state_e;

   typedef enum logic [1:0] {
      H_IDLE = 2'h0,
      H_START = 2'h1,
      H_BIT = 2'h3,
      H_STOP = 2'h2
   } host_state_e;
endpackage

// ---- i2c_expander_if.sv ----
// Purpose: Open-drain wiring between the bus master and the port expander.
// Assumes: Every driver only pulls low; enables are active low.
// Notes: Line levels are resolved here as a wired AND.
`timescale 1ns/10ps
interface i2c_expander_if;
   logic mSclOut;
   logic mSclOeN;
   logic mSdaOut;
   logic mSdaOeN;
   logic dSdaOut;
   logic dSdaOeN;
   logic dAlertOut;
   logic dAlertOeN;
   logic scl;
   logic sda;
   logic alertN;

   assign scl = mSclOeN | mSclOut;
   assign sda = (mSdaOeN | mSdaOut) & (dSdaOeN | dSdaOut);
   assign alertN = dAlertOeN | dAlertOut;

   modport master (
      output mSclOut, mSclOeN, mSdaOut, mSdaOeN,
      input scl, sda, alertN
   );
   modport device (
      output dSdaOut, dSdaOeN, dAlertOut, dAlertOeN,
      input scl, sda
   );
endinterface

// ---- i2c_expander_host.sv ----
// Purpose: Bus master that writes or reads one port pair of the expander.
// Assumes: SCL is made here from the system clock; no clock stretching.
// Notes: One frame is address plus two data bytes, then stop.
`timescale 1ns/10ps
module i2c_expander_host #(
   parameter int QUARTER = i2c_expander_pkg::QUARTER_DEFAULT,
   parameter logic [6:0] TARGET_ADDR = i2c_expander_pkg::DEV_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link
   i2c_expander_if.master link,
   // User command
   input wire logic go,
   input wire logic rnw,
   input wire logic [i2c_expander_pkg::PORT_W-1:0] wrData,
   // User status
   output logic busy_r,
   output logic done_r,
   output logic nackSeen_r,
   output logic alertSeen_r,
   output logic [i2c_expander_pkg::PORT_W-1:0] rdData_r
);
   import i2c_expander_pkg::*;

   if (QUARTER < 2) begin : g_chk
      $error("QUARTER must be at least 2");
   end

   host_state_e state_r;
   logic [15:0] qCnt_r;
   logic [1:0] phase_r;
   logic [3:0] bitIdx_r;
   logic [1:0] byteIdx_r;
   logic rnw_r;
   logic [PORT_W-1:0] wr_r;
   logic [BYTE_W-1:0] rdShift_r;
   logic sclOeN_r;
   logic sdaOeN_r;
   logic [1:0] sclSync_r;
   logic [1:0] sdaSync_r;
   logic [1:0] alertSync_r;
   logic tick;
   logic dataRead;
   logic [BYTE_W-1:0] curByte;

   assign link.mSclOut = 1'b0;
   assign link.mSdaOut = 1'b0;
   assign link.mSclOeN = sclOeN_r;
   assign link.mSdaOeN = sdaOeN_r;

   assign tick = (qCnt_r == 16'(QUARTER - 1));
   assign dataRead = rnw_r && (byteIdx_r != 2'h0);
   always_comb begin
      case (byteIdx_r)
         2'h0: curByte = {TARGET_ADDR, rnw_r};
         2'h1: curByte = wr_r[7:0];
         default: curByte = wr_r[15:8];
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclSync_r <= 2'h3;
         sdaSync_r <= 2'h3;
         alertSync_r <= 2'h3;
         alertSeen_r <= 1'b0;
      end else begin
         sclSync_r <= {sclSync_r[0], link.scl};
         sdaSync_r <= {sdaSync_r[0], link.sda};
         alertSync_r <= {alertSync_r[0], link.alertN};
         alertSeen_r <= !alertSync_r[1];
      end
   end

   // Quarter-bit divider only runs inside a frame
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         qCnt_r <= 16'h0000;
      end else if (state_r == H_IDLE || tick) begin
         qCnt_r <= 16'h0000;
      end else begin
         qCnt_r <= qCnt_r + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= H_IDLE;
         phase_r <= 2'h0;
         bitIdx_r <= 4'h0;
         byteIdx_r <= 2'h0;
         rnw_r <= 1'b0;
         wr_r <= '0;
         rdShift_r <= '0;
         rdData_r <= '0;
         sclOeN_r <= 1'b1;
         sdaOeN_r <= 1'b1;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         nackSeen_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (state_r == H_IDLE) begin
            // Only an idle bus may be claimed
            if (go && sclSync_r[1] && sdaSync_r[1]) begin
               state_r <= H_START;
               phase_r <= 2'h0;
               bitIdx_r <= 4'h0;
               byteIdx_r <= 2'h0;
               rnw_r <= rnw;
               wr_r <= wrData;
               busy_r <= 1'b1;
               nackSeen_r <= 1'b0;
            end
         end else if (tick) begin
            phase_r <= phase_r + 2'h1;
            case (state_r)
               H_START: begin
                  if (phase_r == 2'h0) begin
                     sdaOeN_r <= 1'b0;
                  end
                  if (phase_r == 2'h3) begin
                     state_r <= H_BIT;
                  end
               end
               H_BIT: begin
                  if (phase_r == 2'h0) begin
                     // SDA only moves while SCL is low
                     sclOeN_r <= 1'b0;
                     if (bitIdx_r < BYTE_CNT) begin
                        sdaOeN_r <= dataRead ? 1'b1 : curByte[3'(4'h7 - bitIdx_r)];
                     end else begin
                        // Ack each read byte, leave the last one unacked
                        sdaOeN_r <= dataRead ? (byteIdx_r == LAST_BYTE) : 1'b1;
                     end
                  end else if (phase_r == 2'h2) begin
                     sclOeN_r <= 1'b1;
                  end else if (phase_r == 2'h3) begin
                     if (bitIdx_r < BYTE_CNT) begin
                        rdShift_r <= {rdShift_r[6:0], sdaSync_r[1]};
                        bitIdx_r <= bitIdx_r + 4'h1;
                     end else begin
                        bitIdx_r <= 4'h0;
                        if (dataRead && byteIdx_r == 2'h1) begin
                           rdData_r[7:0] <= rdShift_r;
                        end
                        if (dataRead && byteIdx_r == LAST_BYTE) begin
                           rdData_r[15:8] <= rdShift_r;
                        end
                        if (!dataRead && sdaSync_r[1]) begin
                           nackSeen_r <= 1'b1;
                           state_r <= H_STOP;
                        end else if (byteIdx_r == LAST_BYTE) begin
                           state_r <= H_STOP;
                        end else begin
                           byteIdx_r <= byteIdx_r + 2'h1;
                        end
                     end
                  end
               end
               H_STOP: begin
                  if (phase_r == 2'h0) begin
                     sclOeN_r <= 1'b0;
                     sdaOeN_r <= 1'b0;
                  end else if (phase_r == 2'h1) begin
                     sclOeN_r <= 1'b1;
                  end else if (phase_r == 2'h2) begin
                     sdaOeN_r <= 1'b1;
                  end else begin
                     state_r <= H_IDLE;
                     busy_r <= 1'b0;
                     done_r <= 1'b1;
                  end
               end
               default: state_r <= H_IDLE;
            endcase
         end
      end
   end
endmodule

// ---- i2c_expander_dev.sv ----
// Purpose: Two-wire slave of a 16-bit quasi-bidirectional port with change alert.
// Assumes: SCL and SDA are far slower than clock and are sampled through two flops.
// Notes: Only port bits latched high can raise the alert.
// Functional notes
// - Address bit zero high selects port read
// - Master writes one to input bits first
// - Reset puts registers and slave FSM default
// - Any input edge raises change alert
// - Alert drops on restore, read or write
// - Write releases alert by port pulse end
// - Read pulse clears alert at its start
// - Changes after clearing are detected again
// - Start and stop seen while SCL high
// - SDA stable while SCL high
// - Master starts only on idle bus
// - Receiver acknowledges each byte with low, except the last read byte
// - Slave releases SDA after master nack
// - Write bytes stored low then high, wrapping
// - Write refreshes read-back, clears all alerts
// - Read samples pins per byte, low first
// - Read clears only that byte's alert
// - Read gives pin level or written level
// - Ganged pins always written equal
// - Written ones boosted until next SCL fall
// - Power-on leaves all bits high, weak
// - Byte reaches pins after device ack
`timescale 1ns/10ps
module i2c_expander_dev #(
   parameter logic [6:0] SLAVE_ADDR = i2c_expander_pkg::DEV_ADDR_DEFAULT
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link
   i2c_expander_if.device link,
   // Port pins
   input wire logic [i2c_expander_pkg::PORT_W-1:0] portIn,
   output logic [i2c_expander_pkg::PORT_W-1:0] portLevel_r,
   output logic [i2c_expander_pkg::PORT_W-1:0] portBoost_r
);
   import i2c_expander_pkg::*;

   dev_state_e state_r;
   logic [3:0] bitCnt_r;
   logic [BYTE_W-1:0] rxShift_r;
   logic [BYTE_W-1:0] txShift_r;
   logic rnw_r;
   logic byteHigh_r;
   logic masterAck_r;
   logic sdaOeN_r;
   logic alertOeN_r;
   logic [1:0] sclSync_r;
   logic [1:0] sdaSync_r;
   logic sclPrev_r;
   logic sdaPrev_r;
   logic [PORT_W-1:0] portMeta_r;
   logic [PORT_W-1:0] portSync_r;
   logic [PORT_W-1:0] ref_r;
   logic [1:0] pending;
   logic sclS;
   logic sdaS;
   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;
   logic writePulse;
   logic readLoad;
   logic readSel;
   logic [BYTE_W-1:0] readByte;

   assign link.dSdaOut = 1'b0;
   assign link.dAlertOut = 1'b0;
   assign link.dSdaOeN = sdaOeN_r;
   assign link.dAlertOeN = alertOeN_r;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclSync_r <= 2'h3;
         sdaSync_r <= 2'h3;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         portMeta_r <= PORT_RESET;
         portSync_r <= PORT_RESET;
      end else begin
         sclSync_r <= {sclSync_r[0], link.scl};
         sdaSync_r <= {sdaSync_r[0], link.sda};
         sclPrev_r <= sclSync_r[1];
         sdaPrev_r <= sdaSync_r[1];
         portMeta_r <= portIn;
         portSync_r <= portMeta_r;
      end
   end

   assign sclS = sclSync_r[1];
   assign sdaS = sdaSync_r[1];
   assign sclRise = sclS && !sclPrev_r;
   assign sclFall = !sclS && sclPrev_r;
   // SDA moving while SCL is high is a control condition
   assign startDet = sclS && sclPrev_r && sdaPrev_r && !sdaS;
   assign stopDet = sclS && sclPrev_r && !sdaPrev_r && sdaS;

   // Next read byte: low first after addressing, then alternate
   assign readSel = (state_r == D_MACK) ? !byteHigh_r : byteHigh_r;
   // Pins give outside level on inputs, latch level on outputs
   assign readByte = readSel ? portSync_r[15:8] : portSync_r[7:0];
   assign readLoad = sclFall && (((state_r == D_ACKA) && (rnw_r == RW_READ)) ||
                                 ((state_r == D_MACK) && masterAck_r));
   assign writePulse = sclFall && (state_r == D_ACKW);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         // Power-on default of the slave machine
         state_r <= D_IDLE;
         bitCnt_r <= 4'h0;
         rxShift_r <= '0;
         txShift_r <= '0;
         rnw_r <= 1'b0;
         byteHigh_r <= 1'b0;
         masterAck_r <= 1'b0;
         sdaOeN_r <= 1'b1;
      end else if (startDet) begin
         // Repeated start also restarts at the low byte
         state_r <= D_ADDR;
         bitCnt_r <= 4'h0;
         byteHigh_r <= 1'b0;
         sdaOeN_r <= 1'b1;
      end else if (stopDet) begin
         state_r <= D_IDLE;
         sdaOeN_r <= 1'b1;
      end else if (sclRise) begin
         case (state_r)
            D_ADDR, D_WR: begin
               rxShift_r <= {rxShift_r[6:0], sdaS};
               bitCnt_r <= bitCnt_r + 4'h1;
            end
            D_RD: bitCnt_r <= bitCnt_r + 4'h1;
            D_MACK: masterAck_r <= !sdaS;
            default: ;
         endcase
      end else if (sclFall) begin
         case (state_r)
            D_ADDR: begin
               if (bitCnt_r == BYTE_CNT) begin
                  if (rxShift_r[7:1] == SLAVE_ADDR) begin
                     sdaOeN_r <= 1'b0;
                     rnw_r <= rxShift_r[0];
                     state_r <= D_ACKA;
                  end else begin
                     state_r <= D_IDLE;
                  end
               end
            end
            D_ACKA: begin
               bitCnt_r <= 4'h0;
               if (rnw_r == RW_READ) begin
                  state_r <= D_RD;
                  sdaOeN_r <= readByte[7];
                  txShift_r <= {readByte[6:0], 1'b1};
               end else begin
                  state_r <= D_WR;
                  sdaOeN_r <= 1'b1;
               end
            end
            D_WR: begin
               if (bitCnt_r == BYTE_CNT) begin
                  sdaOeN_r <= 1'b0;
                  state_r <= D_ACKW;
               end
            end
            D_ACKW: begin
               sdaOeN_r <= 1'b1;
               bitCnt_r <= 4'h0;
               byteHigh_r <= !byteHigh_r;
               state_r <= D_WR;
            end
            D_RD: begin
               if (bitCnt_r == BYTE_CNT) begin
                  sdaOeN_r <= 1'b1;
                  state_r <= D_MACK;
               end else begin
                  sdaOeN_r <= txShift_r[7];
                  txShift_r <= {txShift_r[6:0], 1'b1};
               end
            end
            D_MACK: begin
               bitCnt_r <= 4'h0;
               if (masterAck_r) begin
                  byteHigh_r <= !byteHigh_r;
                  state_r <= D_RD;
                  sdaOeN_r <= readByte[7];
                  txShift_r <= {readByte[6:0], 1'b1};
               end else begin
                  // Nack ends the read with SDA left high
                  sdaOeN_r <= 1'b1;
                  state_r <= D_IDLE;
               end
            end
            default: state_r <= D_IDLE;
         endcase
      end
   end

   // Per-byte latch, boost, reference and pending compare
   for (genvar b = 0; b < 2; b++) begin : g_byte
      localparam int LO = b * BYTE_W;
      logic [BYTE_W-1:0] latchNxt;
      logic wrThis;
      logic rdThis;

      assign wrThis = writePulse && (byteHigh_r == 1'(b));
      assign rdThis = readLoad && (readSel == 1'(b));
      assign latchNxt = wrThis ? rxShift_r : portLevel_r[LO +: BYTE_W];

      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            // All bits high, only weak pull-up
            portLevel_r[LO +: BYTE_W] <= PORT_RESET[LO +: BYTE_W];
            portBoost_r[LO +: BYTE_W] <= '0;
         end else if (wrThis) begin
            // Stored at the end of the ack slot, after our ack
            portLevel_r[LO +: BYTE_W] <= rxShift_r;
            portBoost_r[LO +: BYTE_W] <= rxShift_r;
         end else if (sclFall) begin
            portBoost_r[LO +: BYTE_W] <= '0;
         end
      end

      // Outputs driven low never alert: the compare masks them with the latch
      always_ff @(posedge clock or negedge rstn) begin
         if (!rstn) begin
            ref_r[LO +: BYTE_W] <= PORT_RESET[LO +: BYTE_W];
         end else if (writePulse) begin
            // Any write re-arms both bytes
            ref_r[LO +: BYTE_W] <= portSync_r[LO +: BYTE_W] & latchNxt;
         end else if (rdThis) begin
            // Only the byte being read is cleared
            ref_r[LO +: BYTE_W] <= portSync_r[LO +: BYTE_W] & portLevel_r[LO +: BYTE_W];
         end
      end

      // Edge either way alerts; restoring the level withdraws it
      assign pending[b] = (portSync_r[LO +: BYTE_W] & portLevel_r[LO +: BYTE_W]) != ref_r[LO +: BYTE_W];
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         alertOeN_r <= 1'b1;
      end else begin
         alertOeN_r <= !(|pending);
      end
   end
endmodule

// ---- i2c_expander_properties.sv ----
// Purpose: Wire-level checks on the expander link.
// Assumes: Host QUARTER of 8, so one SCL bit spans 32 clocks.
// Notes: Byte position is rebuilt from the sampled lines, not from either end.
`timescale 1ns/10ps
module i2c_expander_properties (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Link enables and lines
   input wire logic mSclOeN,
   input wire logic mSdaOeN,
   input wire logic dSdaOeN,
   input wire logic dAlertOeN,
   input wire logic scl,
   input wire logic sda
);
   logic sclQ_r;
   logic sdaQ_r;
   logic addrPh_r;
   logic readMode_r;
   logic [3:0] slot_r;
   wire logic sclRise = scl & ~sclQ_r;
   wire logic ackRise = sclRise & (slot_r == 4'h8);
   wire logic startSeen = scl & sclQ_r & sdaQ_r & ~sda;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sclQ_r <= 1'b1;
         sdaQ_r <= 1'b1;
      end
      else begin
         sclQ_r <= scl;
         sdaQ_r <= sda;
      end
   end

   // Slot counts SCL rises within a byte; slot 8 is the acknowledge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         slot_r <= 4'h0;
         addrPh_r <= 1'b0;
         readMode_r <= 1'b0;
      end
      else if (startSeen) begin
         slot_r <= 4'h0;
         addrPh_r <= 1'b1;
      end
      else if (sclRise) begin
         slot_r <= ackRise ? 4'h0 : slot_r + 4'h1;
         if (ackRise) begin
            addrPh_r <= 1'b0;
         end
         if (addrPh_r && slot_r == 4'h7) begin
            readMode_r <= sda;
         end
      end
   end

   property p_reset_idle;
      $rose(rstn) |-> dSdaOeN && dAlertOeN && mSdaOeN && mSclOeN;
   endproperty
   a_reset_idle: assert property (p_reset_idle)
      else $error("link not released after reset");

   property p_sda_stable;
      $changed(dSdaOeN) |-> !scl;
   endproperty
   a_sda_stable: assert property (p_sda_stable)
      else $error("device moved SDA while SCL high");

   property p_stop_idle;
      scl && sclQ_r && !sdaQ_r && sda |-> dSdaOeN [*8];
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("device drives SDA after stop");

   property p_addr_ack;
      ackRise && addrPh_r |-> !sda && !dSdaOeN;
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address not acknowledged");

   property p_write_ack;
      ackRise && !addrPh_r && !readMode_r |-> !dSdaOeN;
   endproperty
   a_write_ack: assert property (p_write_ack)
      else $error("write byte not acknowledged");

   property p_read_release;
      ackRise && !addrPh_r && readMode_r |-> dSdaOeN;
   endproperty
   a_read_release: assert property (p_read_release)
      else $error("device holds SDA in master ack slot");

   property p_nack_release;
      ackRise && !addrPh_r && readMode_r && sda |-> dSdaOeN [*8];
   endproperty
   a_nack_release: assert property (p_nack_release)
      else $error("device drives SDA after master nack");

   // Store lands at the fall after the ack rise, about 16 clocks on
   property p_write_alert;
      ackRise && !addrPh_r && !readMode_r |-> ##[1:40] dAlertOeN;
   endproperty
   a_write_alert: assert property (p_write_alert)
      else $error("alert kept through write");
endmodule

// ---- test_i2c_port_expander_read_irq.sv ----
// Purpose: Self-checking bench for master and expander joined on one link.
// Assumes: QUARTER of 8; pins are latched level ANDed with outside drive.
// Notes: Fall 14 of a frame lies inside the first data byte.
`timescale 1ns/10ps
module test_i2c_port_expander_read_irq;
   import i2c_expander_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic go = 1'b0;
   logic rnw = 1'b0;
   logic [PORT_W-1:0] wrData = 16'h0000;
   logic [PORT_W-1:0] extPins = 16'hFFFF;
   logic [PORT_W-1:0] portLevel, portBoost, rdData, boostAcc, midLevel, w, e, m, prev;
   logic busy, done, nackSeen, alertSeen, midAlert;
   logic [4:0] falls = 5'h0;
   int mismatches = 0;
   int num_checks = 0;

   i2c_expander_if i_i2c_expander_if ();
   i2c_expander_host #(.QUARTER(8)) i_i2c_expander_host (.clock(clock), .rstn(rstn),
      .link(i_i2c_expander_if), .go(go), .rnw(rnw), .wrData(wrData), .busy_r(busy), .done_r(done),
      .nackSeen_r(nackSeen), .alertSeen_r(alertSeen), .rdData_r(rdData));
   i2c_expander_dev i_i2c_expander_dev (.clock(clock), .rstn(rstn), .link(i_i2c_expander_if),
      .portIn(portLevel & extPins), .portLevel_r(portLevel), .portBoost_r(portBoost));
   i2c_expander_properties i_i2c_expander_properties (.clock(clock), .rstn(rstn),
      .mSclOeN(i_i2c_expander_if.mSclOeN), .mSdaOeN(i_i2c_expander_if.mSdaOeN),
      .dSdaOeN(i_i2c_expander_if.dSdaOeN), .dAlertOeN(i_i2c_expander_if.dAlertOeN),
      .scl(i_i2c_expander_if.scl), .sda(i_i2c_expander_if.sda));

   always #2.5 clock = ~clock;
   always @(negedge i_i2c_expander_if.scl) falls <= falls + 5'h1;
   always @(posedge clock) begin
      boostAcc <= boostAcc | portBoost;
      if (falls == 5'hE) begin
         midAlert <= i_i2c_expander_if.alertN;
         midLevel <= portLevel;
      end
   end

   function automatic logic [PORT_W-1:0] exp_read(input logic [PORT_W-1:0] wr, input logic [PORT_W-1:0] ext);
      return wr & ext;
   endfunction

   task automatic check_word(input logic [PORT_W-1:0] got, input logic [PORT_W-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_word({15'h0, got}, {15'h0, exp});
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end
      else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Go is held until taken, since the host ignores it while the bus settles
   task automatic run_frame(input logic r, input logic [PORT_W-1:0] d);
      int n;
      n = 0;
      @(negedge clock);
      falls = 5'h0;
      boostAcc = 16'h0000;
      rnw = r;
      wrData = d;
      go = 1'b1;
      while (busy !== 1'b1 && n < 100) begin
         @(negedge clock);
         n++;
      end
      go = 1'b0;
      while (done !== 1'b1 && n < 3000) begin
         @(negedge clock);
         n++;
      end
      check_bit(done, 1'b1);
      check_bit(nackSeen, 1'b0);
   endtask

   task automatic settle;
      repeat (12) @(negedge clock);
   endtask

   initial begin
      void'($urandom(32'h1743));
      repeat (5) @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      check_word(portLevel, PORT_RESET);
      check_word(portBoost, 16'h0000);
      check_bit(alertSeen, 1'b0);
      $display("reset test done");
      prev = PORT_RESET;
      for (int i = 0; i < 6; i++) begin
         w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($urandom());
         // Pins 0 and 1 treated as ganged
         w[1] = w[0];
         e = 16'($urandom());
         run_frame(1'b0, w);
         check_word(midLevel, prev);
         check_word(portLevel, w);
         check_word(boostAcc, w);
         // High boost lasts until the first SCL fall of the next frame
         check_word(portBoost, {w[15:8], 8'h00});
         extPins = e;
         run_frame(1'b1, 16'h0000);
         check_word(rdData, exp_read(w, e));
         prev = w;
         $display("write and read pass %0d done", i);
      end
      // Case 0 moves a low-byte pin, case 1 a high-byte pin
      for (int k = 0; k < 2; k++) begin
         extPins = 16'hFFFF;
         settle();
         run_frame(1'b0, 16'hFFFF);
         // First write may alert on bits it lets rise; second must clear
         run_frame(1'b0, 16'hFFFF);
         check_bit(alertSeen, 1'b0);
         m = 16'h0001 << ($urandom() % 8 + 8 * k);
         extPins = ~m;
         settle();
         check_bit(alertSeen, 1'b1);
         check_bit(i_i2c_expander_if.alertN, 1'b0);
         run_frame(1'b1, 16'h0000);
         check_word(rdData, ~m);
         check_bit(midAlert, 1'(k == 0));
         check_bit(alertSeen, 1'b0);
         extPins = 16'hFFFF;
         settle();
         check_bit(alertSeen, 1'b1);
         extPins = ~m;
         settle();
         check_bit(alertSeen, 1'b0);
         $display("alert case %0d done", k);
      end
      close_out();
   end

   // About 18 frames of some 1000 clocks each, with ample margin
   initial begin
      repeat (80000) @(posedge clock);
      mismatches++;
      close_out();
   end
endmodule
